// *** logic/spdcs_pkg.sv ***
`default_nettype none
package spdcs_pkg;
	// register offsets on the parallel readback port
	localparam logic [6:0] SPDCS_ADDR_W         = 7'h07;
	localparam logic [6:0] SPDCS_OFS_CATEGORY   = 7'h2D;
	localparam logic [6:0] SPDCS_OFS_SOURCE_CH  = 7'h2E;
	localparam logic [6:0] SPDCS_OFS_RATE_ACC   = 7'h2F;
	localparam logic [6:0] SPDCS_OFS_LEN_ORIG   = 7'h30;
	localparam logic [7:0] SPDCS_REG_RESET      = 8'h00;
	// channel status bit window that this bank captures
	localparam logic [5:0] SPDCS_CS_FIRST_BIT   = 6'h08;
	localparam logic [5:0] SPDCS_CS_LAST_BIT    = 6'h27;
	localparam int         SPDCS_CS_BITS        = 32;
	// field positions in the word-length register
	localparam int         SPDCS_MAXLEN_POS     = 0;
	localparam int         SPDCS_LENCODE_LSB    = 1;
	localparam int         SPDCS_SAMPLE_W       = 24;
	// received length codes
	localparam logic [2:0] SPDCS_LEN_NONE       = 3'h0;
	localparam logic [2:0] SPDCS_LEN_C1         = 3'h1;
	localparam logic [2:0] SPDCS_LEN_C2         = 3'h2;
	localparam logic [2:0] SPDCS_LEN_C4         = 3'h4;
	localparam logic [2:0] SPDCS_LEN_C5         = 3'h5;
	localparam logic [2:0] SPDCS_LEN_C6         = 3'h6;

	typedef enum logic [1:0] {
		SPDCS_ST_WAIT    = 2'b01,
		SPDCS_ST_COLLECT = 2'b10
	} spdcs_state_t;
endpackage
`default_nettype wire

// *** logic/spdcs_regs.sv ***
`default_nettype none
// Functional notes
// [R1] category code register shows status bits 15:8; zero means general.
// [R2] status bits 19:16 land in bits 3:0 as source number.
// [R3] status bits 21:20 land in bits 5:4 as first sub-frame channel.
// [R4] status bits 23:22 land in bits 7:6 as second sub-frame channel.
// [R5] status bits 27:24 land in bits 3:0 as sampling rate code.
// [R6] status bits 29:28 land in bits 5:4 as clock accuracy.
// [R7] bit 32 is the max length flag; bits 35:33 the length code.
// [R8] status bits 39:36 land in bits 7:4 as original rate code.
// [R9] only first-channel sub-frames supply status; second channel ignored.
// [R10] update flag sets on new status stored, clears on host readback.
// [R11] truncate sample by recovered length, except the transmitter path.
// [R12] bypass setting 1 passes the sample whole; 0 truncates.
module spdcs_regs
#(
	parameter int SAMPLE_W = 24
) (
	input  wire logic                i_clk,
	input  wire logic                i_arst_n,
	input  wire logic                i_block_start,
	input  wire logic                i_cs_valid,
	input  wire logic                i_cs_bit,
	input  wire logic                i_cs_first_channel,
	input  wire logic                i_rd_en,
	input  wire logic [6:0]          i_rd_addr,
	input  wire logic                i_truncation_bypass,
	input  wire logic                i_sample_valid,
	input  wire logic [SAMPLE_W-1:0] i_sample,
	output var  logic [7:0]          o_rd_data,
	output var  logic                o_rd_valid,
	output var  logic                o_status_update_flag,
	output var  logic                o_out_valid,
	output var  logic [SAMPLE_W-1:0] o_sample_trunc,
	output var  logic [SAMPLE_W-1:0] o_sample_full
);
	import spdcs_pkg::*;

	if (SAMPLE_W != SPDCS_SAMPLE_W)
	begin : g_bad_width
		$error("spdcs_regs: sample width must be 24");
	end

	// the capture window must fill the four status bytes exactly
	if (int'(SPDCS_CS_LAST_BIT) - int'(SPDCS_CS_FIRST_BIT) + 1
		!= SPDCS_CS_BITS || SPDCS_CS_BITS != 32)
	begin : g_bad_window
		$error("spdcs_regs: status window must span 32 bits");
	end

	// the length fields must sit inside the stored word-length byte
	if (SPDCS_MAXLEN_POS > 7 || SPDCS_LENCODE_LSB > 5)
	begin : g_bad_fields
		$error("spdcs_regs: length fields outside the byte");
	end

	typedef struct packed {
		spdcs_state_t             state;
		logic [5:0]               bit_idx;
		logic [SPDCS_CS_BITS-1:0] shift;
		logic [7:0]               category_field;
		logic [7:0]               source_channel;
		logic [7:0]               rate_accuracy;
		logic [7:0]               length_original;
		logic                     status_update_flag;
		logic [7:0]               rd_data;
		logic                     rd_valid;
		logic                     out_valid;
		logic [SAMPLE_W-1:0]      sample_trunc;
		logic [SAMPLE_W-1:0]      sample_full;
	} spdcs_regs_t;

	spdcs_regs_t st_reg;
	spdcs_regs_t st_next;
	logic        take_bit;
	logic        commit;
	logic        rd_hit;

	spdcs_wl_if #(.SAMPLE_W(SAMPLE_W)) wl ();

	assign wl.max_length_flag      =
		st_reg.length_original[SPDCS_MAXLEN_POS];
	assign wl.received_length_code =
		st_reg.length_original[SPDCS_LENCODE_LSB +: 3];
	assign wl.truncation_bypass    = i_truncation_bypass;

	spdcs_trunc #(.SAMPLE_W(SAMPLE_W)) u_trunc (
		.wl (wl)
	);

	always_comb
	begin
		st_next  = st_reg;
		// second-channel sub-frames never advance the capture
		take_bit = i_cs_valid && i_cs_first_channel; // see [R9]
		commit   = 1'b0;
		rd_hit   = 1'b0;

		case (st_reg.state)
			SPDCS_ST_WAIT:
			begin
				// bits ahead of the first block start are dropped
				if (i_block_start && take_bit)
				begin
					st_next.state   = SPDCS_ST_COLLECT;
					st_next.bit_idx = 6'h01;
				end
			end
			SPDCS_ST_COLLECT:
			begin
				if (take_bit)
				begin
					// a block start mid-capture restarts the count
					if (i_block_start)
						st_next.bit_idx = 6'h01;
					else
						st_next.bit_idx = st_reg.bit_idx + 6'h01;
					if (!i_block_start
						&& st_reg.bit_idx >= SPDCS_CS_FIRST_BIT)
						st_next.shift = {i_cs_bit,
							st_reg.shift[SPDCS_CS_BITS-1:1]};
					if (!i_block_start
						&& st_reg.bit_idx == SPDCS_CS_LAST_BIT)
					begin
						commit        = 1'b1;
						st_next.state = SPDCS_ST_WAIT;
					end
				end
			end
			default:
			begin
				st_next.state = SPDCS_ST_WAIT;
			end
		endcase

		// bit 8 ends up in shift[0], so each byte maps straight across
		if (commit)
		begin
			st_next.category_field  = st_next.shift[7:0];   // see [R1]
			st_next.source_channel  = st_next.shift[15:8];  // see [R2] [R3] [R4]
			st_next.rate_accuracy   = st_next.shift[23:16]; // see [R5] [R6]
			st_next.length_original = st_next.shift[31:24]; // see [R7] [R8]
		end

		// unmapped addresses read as zero and leave the flag alone
		st_next.rd_valid = i_rd_en;
		st_next.rd_data  = SPDCS_REG_RESET;
		if (i_rd_en)
		begin
			case (i_rd_addr)
				SPDCS_OFS_CATEGORY:
				begin
					st_next.rd_data = st_reg.category_field;
					rd_hit          = 1'b1;
				end
				SPDCS_OFS_SOURCE_CH:
				begin
					st_next.rd_data = st_reg.source_channel;
					rd_hit          = 1'b1;
				end
				SPDCS_OFS_RATE_ACC:
				begin
					st_next.rd_data = st_reg.rate_accuracy;
					rd_hit          = 1'b1;
				end
				SPDCS_OFS_LEN_ORIG:
				begin
					st_next.rd_data = st_reg.length_original;
					rd_hit          = 1'b1;
				end
				default:
				begin
					st_next.rd_data = SPDCS_REG_RESET;
				end
			endcase
		end

		// a fresh commit beats a readback in the same cycle
		if (commit)
			st_next.status_update_flag = 1'b1; // see [R10]
		else if (rd_hit)
			st_next.status_update_flag = 1'b0; // see [R10]

		// the transmitter path always gets the whole word, never the mask
		st_next.out_valid = i_sample_valid;
		if (i_sample_valid)
		begin
			st_next.sample_full  = i_sample; // see [R11]
			st_next.sample_trunc = i_sample & wl.keep_mask; // see [R11] [R12]
		end
	end

	// the bank reads as zero until the first complete block arrives
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			st_reg.state              <= SPDCS_ST_WAIT;
			st_reg.bit_idx            <= 6'h00;
			st_reg.shift              <= '0;
			st_reg.category_field     <= SPDCS_REG_RESET;
			st_reg.source_channel     <= SPDCS_REG_RESET;
			st_reg.rate_accuracy      <= SPDCS_REG_RESET;
			st_reg.length_original    <= SPDCS_REG_RESET;
			st_reg.status_update_flag <= 1'h0;
			st_reg.rd_data            <= SPDCS_REG_RESET;
			st_reg.rd_valid           <= 1'h0;
			st_reg.out_valid          <= 1'h0;
			st_reg.sample_trunc       <= '0;
			st_reg.sample_full        <= '0;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	assign o_rd_data            = st_reg.rd_data;
	assign o_rd_valid           = st_reg.rd_valid;
	assign o_status_update_flag = st_reg.status_update_flag;
	assign o_out_valid          = st_reg.out_valid;
	assign o_sample_trunc       = st_reg.sample_trunc;
	assign o_sample_full        = st_reg.sample_full;
endmodule // spdcs_regs
`default_nettype wire

// *** logic/spdcs_trunc.sv ***
`default_nettype none
module spdcs_trunc #(
	parameter int SAMPLE_W = 24
) (
	spdcs_wl_if.calc wl
);
	import spdcs_pkg::*;

	if (SAMPLE_W != SPDCS_SAMPLE_W)
	begin : g_bad_width
		$error("spdcs_trunc: sample width must be 24");
	end

	logic [4:0] keep_bits;

	always_comb
	begin
		keep_bits = 5'(SAMPLE_W);
		// length for a 24-bit maximum; a 20-bit maximum is four less
		case (wl.received_length_code)
			SPDCS_LEN_C1: keep_bits = 5'd20;
			SPDCS_LEN_C2: keep_bits = 5'd22;
			SPDCS_LEN_C4: keep_bits = 5'd23;
			SPDCS_LEN_C5: keep_bits = 5'd24;
			SPDCS_LEN_C6: keep_bits = 5'd21;
			// unstated or unlisted codes leave the word whole
			default:      keep_bits = 5'(SAMPLE_W);
		endcase
		if (!wl.max_length_flag && keep_bits != 5'(SAMPLE_W))
			keep_bits = keep_bits - 5'd4;
		else if (!wl.max_length_flag && wl.received_length_code
			== SPDCS_LEN_C5)
			keep_bits = 5'd20;
		if (wl.truncation_bypass)
			keep_bits = 5'(SAMPLE_W); // see [R12]
		// audio is msb aligned, so the low bits are the ones dropped
		wl.keep_mask = ~({SAMPLE_W{1'b1}} >> keep_bits); // see [R11]
	end
endmodule // spdcs_trunc
`default_nettype wire

// *** logic/spdcs_wl_if.sv ***
`default_nettype none
interface spdcs_wl_if #(parameter int SAMPLE_W = 24);
	logic                max_length_flag;
	logic [2:0]          received_length_code;
	logic                truncation_bypass;
	logic [SAMPLE_W-1:0] keep_mask;
	modport src  (output max_length_flag, received_length_code,
		truncation_bypass, input keep_mask);
	modport calc (input max_length_flag, received_length_code,
		truncation_bypass, output keep_mask);
endinterface
`default_nettype wire

// *** tb/spdcs_regs_checker.sv ***
`default_nettype none
module spdcs_regs_checker
	import spdcs_pkg::*;
#(parameter int SAMPLE_W = 24) (
	input wire logic                i_clk,
	input wire logic                i_arst_n,
	input wire logic                i_cs_valid,
	input wire logic                i_cs_first_channel,
	input wire logic                i_rd_en,
	input wire logic [6:0]          i_rd_addr,
	input wire logic                i_truncation_bypass,
	input wire logic                i_sample_valid,
	input wire logic [SAMPLE_W-1:0] i_sample,
	input wire logic [7:0]          o_rd_data,
	input wire logic                o_rd_valid,
	input wire logic                o_status_update_flag,
	input wire logic                o_out_valid,
	input wire logic [SAMPLE_W-1:0] o_sample_trunc,
	input wire logic [SAMPLE_W-1:0] o_sample_full
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	logic map;
	assign map = i_rd_addr >= SPDCS_OFS_CATEGORY
		&& i_rd_addr <= SPDCS_OFS_LEN_ORIG;
	property p_rd_lat; i_rd_en |=> o_rd_valid; endproperty
	a_rd_lat: assert property (p_rd_lat)
		else $error("read answer missing");
	property p_rd_idle;
		!i_rd_en |=> !o_rd_valid && o_rd_data == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read answer without request");
	property p_unmap; i_rd_en && !map |=> o_rd_data == 8'h00; endproperty
	a_unmap: assert property (p_unmap)
		else $error("unmapped read not zero");
	property p_clr;
		i_rd_en && map && !i_cs_valid |=> !o_status_update_flag;
	endproperty
	a_clr: assert property (p_clr)
		else $error("flag not cleared by read");
	property p_hold;
		o_status_update_flag && !(i_rd_en && map) |=> o_status_update_flag;
	endproperty
	a_hold: assert property (p_hold)
		else $error("flag dropped without read");
	property p_set;
		$rose(o_status_update_flag)
			|-> $past(i_cs_valid && i_cs_first_channel);
	endproperty
	a_set: assert property (p_set)
		else $error("flag set without first channel bit");
	property p_full;
		i_sample_valid |=> o_out_valid && o_sample_full == $past(i_sample);
	endproperty
	a_full: assert property (p_full)
		else $error("full sample wrong");
	property p_top;
		i_sample_valid |=> (o_sample_trunc & ~o_sample_full) == '0
			&& o_sample_trunc[SAMPLE_W-1:SAMPLE_W-16]
			== o_sample_full[SAMPLE_W-1:SAMPLE_W-16];
	endproperty
	a_top: assert property (p_top)
		else $error("truncated sample lost kept bits");
	property p_byp;
		i_sample_valid && i_truncation_bypass
			|=> o_sample_trunc == $past(i_sample);
	endproperty
	a_byp: assert property (p_byp)
		else $error("bypass sample truncated");
endmodule // spdcs_regs_checker
bind spdcs_regs spdcs_regs_checker #(.SAMPLE_W(SAMPLE_W)) chk_i (.i_clk,
	.i_arst_n, .i_cs_valid, .i_cs_first_channel, .i_rd_en, .i_rd_addr,
	.i_truncation_bypass, .i_sample_valid, .i_sample, .o_rd_data,
	.o_rd_valid, .o_status_update_flag, .o_out_valid, .o_sample_trunc,
	.o_sample_full);
`default_nettype wire

// *** tb/spdcs_src_model.sv ***
`default_nettype none
module spdcs_src_model (
	input  wire logic i_clk,
	output var  logic o_start,
	output var  logic o_valid,
	output var  logic o_bit,
	output var  logic o_first
);
	timeunit 1ns;
	timeprecision 1ps;
	initial {o_start, o_valid, o_bit, o_first} = 4'h0;
	// channel 2 sub-frames carry inverted bits so any leak shows
	task automatic send(input logic [39:0] cs);
		for (int n = 0; n < 80; n++)
		begin
			@(negedge i_clk);
			o_valid = 1'b1;
			o_first = !n[0];
			o_start = (n == 0);
			o_bit = cs[n / 2] ^ n[0];
		end
		@(negedge i_clk);
		o_valid = 1'b0;
		o_bit = !o_bit;
	endtask
endmodule // spdcs_src_model
`default_nettype wire

// *** tb/test_spdif_rx_channel_status_regs.sv ***
`default_nettype none
module test_spdif_rx_channel_status_regs;
	timeunit 1ns;
	timeprecision 1ps;
	import spdcs_pkg::*;
	logic i_clk = 1'b0, i_arst_n = 1'b0, i_rd_en = 1'b0;
	logic i_truncation_bypass = 1'b0, i_sample_valid = 1'b0;
	logic [6:0] i_rd_addr = 7'h00;
	logic [23:0] i_sample = 24'h000000, o_sample_trunc, o_sample_full, m;
	logic cs_start, cs_valid, cs_bit, cs_first;
	logic o_rd_valid, o_status_update_flag, o_out_valid;
	logic [7:0] o_rd_data, b30;
	logic [2:0] codes [8] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h3, 3'h7};
	int num_errors = 0, compares = 0, cyc = 0;
	always #5 i_clk = ~i_clk;
	spdcs_src_model spdcs_src_model_i (.i_clk, .o_start(cs_start),
		.o_valid(cs_valid), .o_bit(cs_bit), .o_first(cs_first));
	spdcs_regs #(.SAMPLE_W(24)) spdcs_regs_i (.i_clk, .i_arst_n,
		.i_block_start(cs_start), .i_cs_valid(cs_valid), .i_cs_bit(cs_bit),
		.i_cs_first_channel(cs_first), .i_rd_en, .i_rd_addr,
		.i_truncation_bypass, .i_sample_valid, .i_sample, .o_rd_data,
		.o_rd_valid, .o_status_update_flag, .o_out_valid, .o_sample_trunc,
		.o_sample_full);
	task automatic results;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [23:0] exp, got);
		compares++;
		if (got !== exp)
		begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] exp);
		@(negedge i_clk);
		i_rd_en = 1'b1;
		i_rd_addr = a;
		@(negedge i_clk);
		i_rd_en = 1'b0;
		chk("rd_valid", 1'h1, o_rd_valid);
		chk("rd_data", exp, o_rd_data);
	endtask
	task automatic smp(input logic b, input logic [23:0] s, exp);
		@(negedge i_clk);
		i_truncation_bypass = b;
		i_sample_valid = 1'h1;
		i_sample = s;
		@(negedge i_clk);
		i_sample_valid = 1'h0;
		chk("out_valid", 1'h1, o_out_valid);
		chk("full", s, o_sample_full);
		chk("trunc", exp, o_sample_trunc);
	endtask
	task automatic rd_zero;
		for (int a = 0; a < 4; a++)
			rd(7'(SPDCS_OFS_CATEGORY + a), SPDCS_REG_RESET);
	endtask
	// bits kept for the 20-bit maximum; the 24-bit maximum adds four
	function automatic int keep(input logic mx, input logic [2:0] c);
		case (c)
			SPDCS_LEN_C1: keep = 16;
			SPDCS_LEN_C2: keep = 18;
			SPDCS_LEN_C4: keep = 19;
			SPDCS_LEN_C5: keep = 20;
			SPDCS_LEN_C6: keep = 17;
			default: return 24;
		endcase
		return keep + (mx ? 4 : 0);
	endfunction
	initial
	begin
		repeat (4) @(negedge i_clk);
		i_arst_n = 1'h1;
		rd_zero;
		for (int k = 0; k < 16; k++)
		begin
			b30 = {4'(k), codes[k % 8], k >= 8};
			spdcs_src_model_i.send({b30, 8'(k * 19), 8'(k * 21),
				8'(k * 37), 8'hFF});
			chk("flag", 1'h1, o_status_update_flag);
			rd(7'h31, 8'h00);
			chk("flag", 1'h1, o_status_update_flag);
			m = 24'hFFFFFF << (24 - keep(k >= 8, codes[k % 8]));
			smp(1'h0, 24'hFFFFFF, m);
			smp(1'h0, 24'h6B2D95, 24'h6B2D95 & m);
			smp(1'h1, 24'h6B2D95, 24'h6B2D95);
			rd(SPDCS_OFS_CATEGORY, 8'(k * 37));
			chk("flag", 1'h0, o_status_update_flag);
			rd(SPDCS_OFS_SOURCE_CH, 8'(k * 21));
			rd(SPDCS_OFS_RATE_ACC, 8'(k * 19));
			rd(SPDCS_OFS_LEN_ORIG, b30);
		end
		// a reset in mid-run must wipe a freshly stored block
		spdcs_src_model_i.send(40'hFFFFFFFFFF);
		chk("flag", 1'h1, o_status_update_flag);
		i_arst_n = 1'h0;
		repeat (2) @(negedge i_clk);
		i_arst_n = 1'h1;
		chk("flag", 1'h0, o_status_update_flag);
		rd_zero;
		smp(1'h0, 24'h6B2D95, 24'h6B2D95);
		results;
	end
	always @(posedge i_clk)
	begin
		cyc++;
		if (cyc == 4000)
		begin
			num_errors++;
			results;
		end
	end
endmodule // test_spdif_rx_channel_status_regs
`default_nettype wire
